// ==== src/fdsc_pkg.sv ====
// fdsc_pkg: register map, field layout and codes for the floppy drive signal control block
package fdsc_pkg;

   localparam int AW = 4;
   localparam int DW = 8;

   // register indices on the plain register port
   localparam logic [AW-1:0] ADR_FER   = 4'h0;
   localparam logic [AW-1:0] ADR_FCR   = 4'h1;
   localparam logic [AW-1:0] ADR_DOR   = 4'h2;
   localparam logic [AW-1:0] ADR_SRA   = 4'h3;
   localparam logic [AW-1:0] ADR_DSR   = 4'h4;
   localparam logic [AW-1:0] ADR_MODE  = 4'h5;
   localparam logic [AW-1:0] ADR_OPCTL = 4'h6;
   localparam logic [AW-1:0] ADR_CCR   = 4'h7;
   localparam logic [AW-1:0] ADR_CFG   = 4'h8;

   localparam logic [DW-1:0] RST_REG   = 8'h00;
   localparam logic [DW-1:0] RD_UNMAP  = 8'h00;

   // field positions
   localparam int FER_ENC_BIT   = 4;
   localparam int FCR_SWAP_BIT  = 4;
   localparam int DOR_SEL_LSB   = 0;
   localparam int DOR_MTR_LSB   = 4;
   localparam int RATE_LSB      = 0;
   localparam int MODE_DENS_LSB = 0;
   localparam int OP_SEEK_BIT   = 0;
   localparam int OP_INWARD_BIT = 1;
   localparam int OP_RW_BIT     = 2;
   localparam int CFG_PPM_BIT   = 0;
   localparam int CFG_PNF_BIT   = 1;
   localparam int CFG_ALT_BIT   = 2;
   localparam int SRA_DIR_BIT   = 0;
   localparam int SRA_DENS_BIT  = 1;
   localparam int SRA_DSEL_LSB  = 2;
   localparam int SRA_SECOND_DRIVE_PRESENT_BIT  = 6;

   // data rate codes in the two rate bits
   localparam logic [1:0] RATE_500K = 2'h0;
   localparam logic [1:0] RATE_300K = 2'h1;
   localparam logic [1:0] RATE_250K = 2'h2;
   localparam logic [1:0] RATE_1M   = 2'h3;
   localparam logic [1:0] RST_RATE  = RATE_500K;

   // density polarity programming
   localparam logic [1:0] DENS_BY_STRAP = 2'h0;
   localparam logic [1:0] DENS_ACT_HIGH = 2'h1;
   localparam logic [1:0] DENS_ACT_LOW  = 2'h2;

   localparam logic [1:0] DSEL_IDLE = 2'h3;

endpackage

// ==== src/fdsc_drv_if.sv ====
// fdsc_drv_if: register state toward the decode modules and their results back
`timescale 1ns/100ps
`default_nettype none
interface fdsc_drv_if;
   logic [7:0] digital_output_reg;
   logic       enc_en;
   logic       swap_en;
   logic [1:0] rate;
   logic       ident;
   logic [1:0] dens_mode;
   logic       seek_act;
   logic       seek_in;
   logic       rw_act;
   logic [1:0] dsel_n;
   logic       dens;
   logic       dir;

   modport ctl_mp (output digital_output_reg, enc_en, swap_en, rate, ident, dens_mode, seek_act, seek_in, rw_act,
                   input  dsel_n, dens, dir);
   modport sel_mp (input  digital_output_reg, enc_en, swap_en,
                   output dsel_n);
   modport pol_mp (input  rate, ident, dens_mode, seek_act, seek_in, rw_act,
                   output dens, dir);
endinterface
`default_nettype wire

// ==== src/fdsc_dsel.sv ====
// fdsc_dsel: drive select decode, encode and drive 0/1 swap
`timescale 1ns/100ps
`default_nettype none
module fdsc_dsel (
   fdsc_drv_if.sel_mp d
);
   always_comb begin
      logic [1:0] lsel;
      logic [1:0] psel;
      logic [3:0] mtr;
      logic       on;
      lsel = d.digital_output_reg[fdsc_pkg::DOR_SEL_LSB +: 2];
      mtr  = d.digital_output_reg[fdsc_pkg::DOR_MTR_LSB +: 4];
      on   = mtr[lsel];
      psel = (d.swap_en && !lsel[1]) ? {lsel[1], ~lsel[0]} : lsel;
      if (d.enc_en) begin
         d.dsel_n = on ? psel : fdsc_pkg::DSEL_IDLE;
      end else begin
         d.dsel_n[0] = !(on && psel == 2'h0);
         d.dsel_n[1] = !(on && psel == 2'h1);
      end
   end
endmodule
`default_nettype wire

// ==== src/fdsc_pol.sv ====
// fdsc_pol: density select polarity and head direction
`timescale 1ns/100ps
`default_nettype none
module fdsc_pol (
   fdsc_drv_if.pol_mp p
);
   always_comb begin
      logic hi;
      logic act_high;
      act_high = p.ident;
      hi = (p.rate == fdsc_pkg::RATE_500K) || (p.rate == fdsc_pkg::RATE_1M);
      case (p.dens_mode)
         fdsc_pkg::DENS_ACT_HIGH: act_high = 1'b1;
         fdsc_pkg::DENS_ACT_LOW:  act_high = 1'b0;
         default:                 act_high = p.ident;
      endcase
      p.dens = act_high ? hi : !hi;
      p.dir  = p.seek_act && p.seek_in && !p.rw_act;
   end
endmodule
`default_nettype wire

// ==== src/fdsc_top.sv ====
// fdsc_top: floppy drive signal control, registers, pin outputs and checks
//
// How it works
// - density output asserted for 500k and 1M rates, not for 250k or 300k
// - strap high gives active-high density, strap low gives active-low
// - mode register can program density polarity instead of the strap
// - during seek, direction output active steps in, inactive steps out
// - direction output held inactive while a read or write runs
// - two active-low drive selects decoded from select bits, gated by motor bits
// - function enable bit 4 switches drive selects to encoded four-drive form
// - function control bit 4 swaps logical drives 0 and 1
// - parallel-port floppy mode with flag 0 duplicates density, direction, select
// - in decoded form, duplicated select carries drive 1 when swap bit 0, drive 0 when 1
// - rate pins follow the rate bits of whichever rate register was written last
// - second-drive input readable in status A in alternate compatibility mode
`timescale 1ns/100ps
`default_nettype none
module fdsc_top (
   // clock and reset
   input  wire logic                    mclk_i,
   input  wire logic                    reset_i,
   // register port
   input  wire logic [fdsc_pkg::AW-1:0] addr_i,
   input  wire logic [fdsc_pkg::DW-1:0] wdata_i,
   input  wire logic                    wr_i,
   input  wire logic                    rd_i,
   output logic      [fdsc_pkg::DW-1:0] rdata_o,
   // drive side inputs
   input  wire logic                    ident_strap_i,
   input  wire logic                    second_drive_present_i,
   // drive side outputs
   output logic                         density_select_out_o,
   output logic                         head_dir_o,
   output logic      [1:0]              drive_select_n_o,
   output logic      [1:0]              rate_indicator_out_o,
   // parallel-port floppy duplicates
   output logic                         ppm_oe_o,
   output logic                         ppm_density_o,
   output logic                         ppm_dir_o,
   output logic                         ppm_dsel_n_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // registers

   logic [fdsc_pkg::DW-1:0] function_enable_reg_ff;
   logic [fdsc_pkg::DW-1:0] function_control_reg_ff;
   logic [fdsc_pkg::DW-1:0] digital_output_reg_ff;
   logic [fdsc_pkg::DW-1:0] rate_select_reg_ff;
   logic [fdsc_pkg::DW-1:0] config_control_reg_ff;
   logic [fdsc_pkg::DW-1:0] mode_reg_ff;
   logic [fdsc_pkg::DW-1:0] op_ctl_reg_ff;
   logic [fdsc_pkg::DW-1:0] cfg_reg_ff;
   logic [1:0]              rate_ff;
   logic [fdsc_pkg::DW-1:0] nxt_rdata;

   logic wr_fer;
   logic wr_fcr;
   logic wr_dor;
   logic wr_dsr;
   logic wr_ccr;
   logic wr_mode;
   logic wr_op;
   logic wr_cfg;

   assign wr_fer  = wr_i && (addr_i == fdsc_pkg::ADR_FER);
   assign wr_fcr  = wr_i && (addr_i == fdsc_pkg::ADR_FCR);
   assign wr_dor  = wr_i && (addr_i == fdsc_pkg::ADR_DOR);
   assign wr_dsr  = wr_i && (addr_i == fdsc_pkg::ADR_DSR);
   assign wr_ccr  = wr_i && (addr_i == fdsc_pkg::ADR_CCR);
   assign wr_mode = wr_i && (addr_i == fdsc_pkg::ADR_MODE);
   assign wr_op   = wr_i && (addr_i == fdsc_pkg::ADR_OPCTL);
   assign wr_cfg  = wr_i && (addr_i == fdsc_pkg::ADR_CFG);

   // software-visible register storage
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         function_enable_reg_ff  <= fdsc_pkg::RST_REG;
         function_control_reg_ff <= fdsc_pkg::RST_REG;
         digital_output_reg_ff   <= fdsc_pkg::RST_REG;
         rate_select_reg_ff      <= fdsc_pkg::RST_REG;
         config_control_reg_ff   <= fdsc_pkg::RST_REG;
         mode_reg_ff             <= fdsc_pkg::RST_REG;
         op_ctl_reg_ff           <= fdsc_pkg::RST_REG;
         cfg_reg_ff              <= fdsc_pkg::RST_REG;
      end else begin
         if (wr_fer) begin
            function_enable_reg_ff <= wdata_i;
         end
         if (wr_fcr) begin
            function_control_reg_ff <= wdata_i;
         end
         if (wr_dor) begin
            digital_output_reg_ff <= wdata_i;
         end
         if (wr_dsr) begin
            rate_select_reg_ff <= wdata_i;
         end
         if (wr_ccr) begin
            config_control_reg_ff <= wdata_i;
         end
         if (wr_mode) begin
            mode_reg_ff <= wdata_i;
         end
         if (wr_op) begin
            op_ctl_reg_ff <= wdata_i;
         end
         if (wr_cfg) begin
            cfg_reg_ff <= wdata_i;
         end
      end
   end

   // effective rate: last write to either rate register wins
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         rate_ff <= fdsc_pkg::RST_RATE;
      end else if (wr_dsr || wr_ccr) begin
         rate_ff <= wdata_i[fdsc_pkg::RATE_LSB +: 2];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // decode modules

   fdsc_drv_if drv ();

   assign drv.digital_output_reg       = digital_output_reg_ff;
   assign drv.enc_en    = function_enable_reg_ff[fdsc_pkg::FER_ENC_BIT];
   assign drv.swap_en   = function_control_reg_ff[fdsc_pkg::FCR_SWAP_BIT];
   assign drv.rate      = rate_ff;
   assign drv.ident     = ident_strap_i;
   assign drv.dens_mode = mode_reg_ff[fdsc_pkg::MODE_DENS_LSB +: 2];
   assign drv.seek_act  = op_ctl_reg_ff[fdsc_pkg::OP_SEEK_BIT];
   assign drv.seek_in   = op_ctl_reg_ff[fdsc_pkg::OP_INWARD_BIT];
   assign drv.rw_act    = op_ctl_reg_ff[fdsc_pkg::OP_RW_BIT];

   fdsc_dsel u_dsel (
      .d (drv.sel_mp)
   );

   fdsc_pol u_pol (
      .p (drv.pol_mp)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // pin outputs, one edge behind the registers

   logic ppm_act;
   logic dup_dsel_n;

   assign ppm_act = cfg_reg_ff[fdsc_pkg::CFG_PPM_BIT] && !cfg_reg_ff[fdsc_pkg::CFG_PNF_BIT];
   // duplicated pin is whichever physical pin holds logical drive 1 when unswapped
   assign dup_dsel_n = drv.dsel_n[1];

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         density_select_out_o <= 1'b0;
         head_dir_o           <= 1'b0;
         drive_select_n_o     <= fdsc_pkg::DSEL_IDLE;
         rate_indicator_out_o <= fdsc_pkg::RST_RATE;
      end else begin
         density_select_out_o <= drv.dens;
         head_dir_o           <= drv.dir;
         drive_select_n_o     <= drv.dsel_n;
         rate_indicator_out_o <= rate_ff;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         ppm_oe_o      <= 1'b0;
         ppm_density_o <= 1'b0;
         ppm_dir_o     <= 1'b0;
         ppm_dsel_n_o  <= 1'b1;
      end else begin
         ppm_oe_o      <= ppm_act;
         ppm_density_o <= ppm_act && drv.dens;
         ppm_dir_o     <= ppm_act && drv.dir;
         ppm_dsel_n_o  <= !ppm_act || dup_dsel_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read port

   always_comb begin
      nxt_rdata = fdsc_pkg::RD_UNMAP;
      case (addr_i)
         fdsc_pkg::ADR_FER:   nxt_rdata = function_enable_reg_ff;
         fdsc_pkg::ADR_FCR:   nxt_rdata = function_control_reg_ff;
         fdsc_pkg::ADR_DOR:   nxt_rdata = digital_output_reg_ff;
         fdsc_pkg::ADR_DSR:   nxt_rdata = rate_select_reg_ff;
         fdsc_pkg::ADR_CCR:   nxt_rdata = config_control_reg_ff;
         fdsc_pkg::ADR_MODE:  nxt_rdata = mode_reg_ff;
         fdsc_pkg::ADR_OPCTL: nxt_rdata = op_ctl_reg_ff;
         fdsc_pkg::ADR_CFG:   nxt_rdata = cfg_reg_ff;
         fdsc_pkg::ADR_SRA: begin
            nxt_rdata[fdsc_pkg::SRA_DIR_BIT]       = head_dir_o;
            nxt_rdata[fdsc_pkg::SRA_DENS_BIT]      = density_select_out_o;
            nxt_rdata[fdsc_pkg::SRA_DSEL_LSB +: 2] = drive_select_n_o;
            nxt_rdata[fdsc_pkg::SRA_SECOND_DRIVE_PRESENT_BIT]      =
               cfg_reg_ff[fdsc_pkg::CFG_ALT_BIT] && second_drive_present_i;
         end
         default: nxt_rdata = fdsc_pkg::RD_UNMAP;
      endcase
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         rdata_o <= fdsc_pkg::RD_UNMAP;
      end else if (rd_i) begin
         rdata_o <= nxt_rdata;
      end else begin
         rdata_o <= fdsc_pkg::RD_UNMAP;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (reset_i);

   property p_dens_rate;
      (mode_reg_ff[1:0] == fdsc_pkg::DENS_ACT_HIGH) && !wr_i
      |=> density_select_out_o ==
          (($past(rate_ff) == fdsc_pkg::RATE_500K) || ($past(rate_ff) == fdsc_pkg::RATE_1M));
   endproperty
   a_dens_rate: assert property (p_dens_rate)
      else $error("density output does not follow the data rate");

   property p_dens_strap;
      (mode_reg_ff[1:0] == fdsc_pkg::DENS_BY_STRAP) && !ident_strap_i &&
      (rate_ff == fdsc_pkg::RATE_250K)
      |=> density_select_out_o;
   endproperty
   a_dens_strap: assert property (p_dens_strap)
      else $error("low strap with low density rate must drive density high");

   property p_dens_mode;
      (mode_reg_ff[1:0] == fdsc_pkg::DENS_ACT_LOW) && (rate_ff == fdsc_pkg::RATE_1M)
      |=> !density_select_out_o;
   endproperty
   a_dens_mode: assert property (p_dens_mode)
      else $error("programmed active-low density not honoured");

   property p_dir_seek;
      wr_op && wdata_i[fdsc_pkg::OP_SEEK_BIT] && !wdata_i[fdsc_pkg::OP_RW_BIT]
      ##1 !wr_i
      |=> head_dir_o == $past(op_ctl_reg_ff[fdsc_pkg::OP_INWARD_BIT]);
   endproperty
   a_dir_seek: assert property (p_dir_seek)
      else $error("direction output wrong during seek");

   property p_dir_rw;
      op_ctl_reg_ff[fdsc_pkg::OP_RW_BIT] |=> !head_dir_o;
   endproperty
   a_dir_rw: assert property (p_dir_rw)
      else $error("direction output active during read or write");

   property p_dsel_dec;
      !drv.enc_en && !drv.swap_en
      |=> drive_select_n_o[0] ==
          !($past(digital_output_reg_ff[1:0]) == 2'h0 && $past(digital_output_reg_ff[4]));
   endproperty
   a_dsel_dec: assert property (p_dsel_dec)
      else $error("decoded drive select 0 wrong");

   property p_dsel_enc;
      drv.enc_en && !drv.swap_en && digital_output_reg_ff[6] &&
      (digital_output_reg_ff[1:0] == 2'h2)
      |=> drive_select_n_o == 2'h2;
   endproperty
   a_dsel_enc: assert property (p_dsel_enc)
      else $error("encoded drive select wrong");

   property p_dsel_swap;
      !drv.enc_en && drv.swap_en && digital_output_reg_ff[4] &&
      (digital_output_reg_ff[1:0] == 2'h0)
      |=> drive_select_n_o == 2'h1;
   endproperty
   a_dsel_swap: assert property (p_dsel_swap)
      else $error("swapped drive 0 not on second select");

   property p_ppm_dup;
      ppm_act |=> ppm_oe_o && (ppm_density_o == density_select_out_o) &&
                  (ppm_dir_o == head_dir_o);
   endproperty
   a_ppm_dup: assert property (p_ppm_dup)
      else $error("parallel-port duplicates do not match");

   property p_ppm_sel;
      ppm_act |=> ppm_dsel_n_o == drive_select_n_o[1];
   endproperty
   a_ppm_sel: assert property (p_ppm_sel)
      else $error("duplicated drive select on wrong drive");

   property p_rate_last;
      (wr_dsr || wr_ccr) ##1 !(wr_dsr || wr_ccr)
      |=> rate_indicator_out_o == $past(wdata_i[1:0], 2);
   endproperty
   a_rate_last: assert property (p_rate_last)
      else $error("rate pins do not follow last rate write");

   property p_sra_second_drive_present;
      rd_i && (addr_i == fdsc_pkg::ADR_SRA) && cfg_reg_ff[fdsc_pkg::CFG_ALT_BIT]
      |=> rdata_o[fdsc_pkg::SRA_SECOND_DRIVE_PRESENT_BIT] == $past(second_drive_present_i);
   endproperty
   a_sra_second_drive_present: assert property (p_sra_second_drive_present)
      else $error("status A second-drive bit wrong");

   property p_out_timing;
      $changed(drive_select_n_o) || $changed(rate_indicator_out_o)
      |-> $past(wr_i, 2);
   endproperty
   a_out_timing: assert property (p_out_timing)
      else $error("drive output changed without a write two edges before");

   property p_dsel_dec1;
      !drv.enc_en && !drv.swap_en
      |=> drive_select_n_o[1] ==
          !($past(drv.digital_output_reg[fdsc_pkg::DOR_SEL_LSB +: 2]) == 2'h1 &&
            $past(drv.digital_output_reg[fdsc_pkg::DOR_MTR_LSB + 1]));
   endproperty
   a_dsel_dec1: assert property (p_dsel_dec1)
      else $error("decoded drive select 1 wrong");

   property p_dsel_swap_enc;
      drv.enc_en && drv.swap_en && drv.digital_output_reg[fdsc_pkg::DOR_MTR_LSB + 1] &&
      (drv.digital_output_reg[fdsc_pkg::DOR_SEL_LSB +: 2] == 2'h1)
      |=> drive_select_n_o == 2'h0;
   endproperty
   a_dsel_swap_enc: assert property (p_dsel_swap_enc)
      else $error("swapped drive 1 not encoded as drive 0");

   property p_dir_in;
      drv.seek_act && drv.seek_in && !drv.rw_act |=> head_dir_o;
   endproperty
   a_dir_in: assert property (p_dir_in)
      else $error("direction output not active for inward seek");

   property p_ppm_off;
      !ppm_act |=> !ppm_oe_o && !ppm_density_o && !ppm_dir_o && ppm_dsel_n_o;
   endproperty
   a_ppm_off: assert property (p_ppm_off)
      else $error("parallel-port duplicates active outside floppy mode");

   property p_sra_alt_off;
      rd_i && (addr_i == fdsc_pkg::ADR_SRA) && !cfg_reg_ff[fdsc_pkg::CFG_ALT_BIT]
      |=> !rdata_o[fdsc_pkg::SRA_SECOND_DRIVE_PRESENT_BIT];
   endproperty
   a_sra_alt_off: assert property (p_sra_alt_off)
      else $error("status A second-drive bit set outside alternate mode");

endmodule
`default_nettype wire

// ==== verification/fdsc_drive_model.sv ====
// fdsc_drive_model: floppy drive as seen from the drive cable
`timescale 1ns/100ps
`default_nettype none
module fdsc_drive_model (
   // clock
   input  wire logic       mclk_i,
   // cable from the controller
   input  wire logic [1:0] drive_select_n_i,
   input  wire logic       head_dir_i,
   // bench command: second drive fitted or not
   input  wire logic       installed_i,
   // cable back to the controller
   output logic            second_drive_present_o,
   output logic [1:0]      sel_seen_o,
   output logic            dir_seen_o
);
   // presence is a plain strap level on the drive side
   assign second_drive_present_o = installed_i;

   // drive latches what it sees on the cable each cycle
   always_ff @(posedge mclk_i) begin
      sel_seen_o <= ~drive_select_n_i;
      dir_seen_o <= head_dir_i;
   end
endmodule
`default_nettype wire

// ==== verification/test_floppy_drive_signal_control.sv ====
// test_floppy_drive_signal_control: self-checking bench with a behavioural register model
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin \
   $display("wrong value %s exp %0h got %0h", nm, ex, gt); num_errors++; end end
module test_floppy_drive_signal_control;
   logic       mclk_i, reset_i, wr_s, rd_s, strap, inst;
   logic [3:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       dens, dir, oe, pdens, pdir, pdsel, second_drive_present;
   logic [1:0] dsel, rate_o, sel_seen;
   logic       dir_seen;
   int         num_errors, compares, cycles;
   int         function_enable_reg, function_control_reg, digital_output_reg, dsr, mode, op, config_control_reg, cfg, rate;

   fdsc_top dut (.mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s),
      .rd_i(rd_s), .rdata_o(rdata), .ident_strap_i(strap), .second_drive_present_i(second_drive_present),
      .density_select_out_o(dens), .head_dir_o(dir), .drive_select_n_o(dsel),
      .rate_indicator_out_o(rate_o), .ppm_oe_o(oe), .ppm_density_o(pdens), .ppm_dir_o(pdir),
      .ppm_dsel_n_o(pdsel));
   fdsc_drive_model drive (.mclk_i(mclk_i), .drive_select_n_i(dsel), .head_dir_i(dir),
      .installed_i(inst), .second_drive_present_o(second_drive_present), .sel_seen_o(sel_seen),
      .dir_seen_o(dir_seen));

   initial begin
      mclk_i = 1'b0;
      forever #2.5 mclk_i = ~mclk_i;
   end

   ////////////////////////////////////////////////////////////////////////////
   // behavioural model of the pins
   function automatic int e_dsel();
      int s, m, p;
      s = digital_output_reg & 3;
      m = (digital_output_reg >> (4 + s)) & 1;
      p = (((function_control_reg >> 4) & 1) && s < 2) ? s ^ 1 : s;
      if ((function_enable_reg >> 4) & 1) return m ? p : 3;
      return !m ? 3 : (p == 0) ? 2 : (p == 1) ? 1 : 3;
   endfunction
   function automatic int e_dens();
      int hd, hi;
      hd = (rate == 0 || rate == 3);
      hi = ((mode & 3) == 1) ? 1 : ((mode & 3) == 2) ? 0 : int'(strap);
      return hi ? hd : !hd;
   endfunction
   function automatic int e_dir();
      return (op & 1) && ((op >> 1) & 1) && !((op >> 2) & 1);
   endfunction
   function automatic int e_oe();
      return (cfg & 1) && !((cfg >> 1) & 1);
   endfunction
   function automatic int e_rd(input int a);
      case (a)
         0: return function_enable_reg;
         1: return function_control_reg;
         2: return digital_output_reg;
         3: return e_dir() | (e_dens() << 1) | (e_dsel() << 2) | ((((cfg >> 2) & 1) && second_drive_present) << 6);
         4: return dsr;
         5: return mode;
         6: return op;
         7: return config_control_reg;
         8: return cfg;
         default: return 0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // comparisons and bus cycles
   task automatic check_pins();
      `CHK("density", e_dens(), dens)
      `CHK("head_dir", e_dir(), dir)
      `CHK("drive_select_n", e_dsel(), dsel)
      `CHK("rate_pins", rate, rate_o)
      `CHK("ppm_oe", e_oe(), oe)
      `CHK("ppm_density", e_oe() ? e_dens() : 0, pdens)
      `CHK("ppm_dir", e_oe() ? e_dir() : 0, pdir)
      `CHK("ppm_dsel_n", e_oe() ? (e_dsel() >> 1) & 1 : 1, pdsel)
   endtask
   task automatic wr(input int a, input int d);
      @(posedge mclk_i);
      addr <= 4'(a);
      wdata <= 8'(d);
      wr_s <= 1'b1;
      @(posedge mclk_i);
      wr_s <= 1'b0;
      #1 check_pins();
      `CHK("drive_seen", (e_dsel() << 1) | e_dir(), {~sel_seen, dir_seen})
      case (a)
         0: function_enable_reg = d;
         1: function_control_reg = d;
         2: digital_output_reg = d;
         4: begin dsr = d; rate = d & 3; end
         5: mode = d;
         6: op = d;
         7: begin config_control_reg = d; rate = d & 3; end
         8: cfg = d;
         default: ;
      endcase
      @(posedge mclk_i);
      #1 check_pins();
   endtask
   task automatic rd(input int a);
      @(posedge mclk_i);
      addr <= 4'(a);
      rd_s <= 1'b1;
      @(posedge mclk_i);
      rd_s <= 1'b0;
      #1 `CHK("rdata", e_rd(a), rdata)
   endtask
   task automatic do_reset();
      reset_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      reset_i <= 1'b0;
      {function_enable_reg, function_control_reg, digital_output_reg, dsr, mode, op, config_control_reg, cfg, rate} = '0;
      repeat (2) @(posedge mclk_i);
      #1 check_pins();
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 30000) begin
         num_errors++;
         final_report();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      reset_i = 1'b1;
      {wr_s, rd_s, strap, inst, addr, wdata} = '0;
      {num_errors, compares, cycles} = '0;
      void'($urandom(32'hd96d7545));
      do_reset();
      for (int a = 0; a < 16; a++) rd(a);
      $display("test reset values done");
      for (int a = 0; a < 16; a++) begin
         wr(a, $urandom & 8'hFF);
         rd(a);
      end
      @(posedge mclk_i) do_reset();
      for (int a = 0; a < 9; a++) rd(a);
      $display("test register access done");
      for (int i = 0; i < 8; i++) wr((i % 2) ? 7 : 4, $urandom & 8'hFF);
      $display("test rate source done");
      for (int m = 0; m < 4; m++)
         for (int s = 0; s < 2; s++)
            for (int r = 0; r < 4; r++) begin
               @(posedge mclk_i) strap <= 1'(s);
               wr(5, m);
               wr((r % 2) ? 4 : 7, r);
            end
      $display("test density done");
      for (int o = 0; o < 8; o++) wr(6, o);
      $display("test direction done");
      for (int e = 0; e < 2; e++)
         for (int w = 0; w < 2; w++)
            for (int s = 0; s < 12; s++) begin
               wr(0, e << 4);
               wr(1, w << 4);
               wr(2, (s % 4) | ((s < 4) ? 8'hF0 : $urandom & 8'hF0));
            end
      $display("test drive select done");
      for (int c = 0; c < 16; c++) begin
         @(posedge mclk_i) inst <= c[3];
         wr(8, c & 7);
         wr(1, $urandom & 8'h10);
         wr(2, $urandom & 8'hF3);
         rd(3);
      end
      $display("test parallel port and status done");
      for (int i = 0; i < 300; i++) begin
         @(posedge mclk_i) strap <= 1'($urandom);
         wr($urandom % 16, $urandom & 8'hFF);
         if (i % 4 == 0) rd($urandom % 16);
      end
      $display("test random traffic done");
      final_report();
   end
endmodule
`default_nettype wire
